// >>> src/startup_cfg_pkg.sv
// Offsets, field layout and scales of the open-loop start-up register
package startup_cfg_pkg;
  // Printed offset is a register index; byte address is four times it
  localparam logic [9:0]  CFG_INDEX        = 10'h084;
  localparam logic [11:0] CFG_BYTE_ADDR    = {CFG_INDEX, 2'b00};
  localparam logic [31:0] CFG_RESET        = 32'h0000_0000;
  localparam logic [31:0] CFG_WRITE_MASK   = 32'hFFFF_FFFC;
  localparam int          PARITY_BIT       = 31;
  localparam int          LIMIT_SEL_BIT    = 30;
  localparam int          CEILING_MSB      = 29;
  localparam int          CEILING_LSB      = 27;
  localparam int          THRESH_MSB       = 26;
  localparam int          THRESH_LSB       = 23;
  localparam int          ACCEL_ONE_MSB    = 22;
  localparam int          ACCEL_ONE_LSB    = 18;
  localparam int          ACCEL_TWO_MSB    = 17;
  localparam int          ACCEL_TWO_LSB    = 13;
  localparam int          HANDOFF_MSB      = 12;
  localparam int          HANDOFF_LSB      = 8;
  localparam int          AUTO_HANDOFF_BIT = 7;
  localparam int          FIRST_CYC_BIT    = 6;
  localparam int          MIN_DUTY_MSB     = 5;
  localparam int          MIN_DUTY_LSB     = 2;
  localparam logic [4:0]  ACCEL_NO_LIMIT   = 5'h1F;
  localparam int          ACCEL_SATURATED  = 32767;
  // Acceleration values are carried in thousandths of a unit
  localparam int          ACCEL_SCALE      = 1000;
  localparam int          ACCEL_WIDTH      = 25;
  localparam logic [10:0] THRESH_STEP_MV   = 11'd100;
endpackage

// >>> src/accel_coef_decoder.sv
// Acceleration coefficient code to value in thousandths
`timescale 1ns/1ps
module accel_coef_decoder (
  input  wire logic [4:0]                              code_in,
  output logic      [startup_cfg_pkg::ACCEL_WIDTH-1:0] value_out,
  output logic                                         unlimited_out
);
  localparam logic [startup_cfg_pkg::ACCEL_WIDTH-1:0] SAT_VALUE =
    startup_cfg_pkg::ACCEL_WIDTH'(startup_cfg_pkg::ACCEL_SATURATED *
                                  startup_cfg_pkg::ACCEL_SCALE);

  assign unlimited_out = (code_in == startup_cfg_pkg::ACCEL_NO_LIMIT);

  always_comb begin
    case (code_in)
      5'h00:   value_out = 25'd5;
      5'h01:   value_out = 25'd10;
      5'h02:   value_out = 25'd25;
      5'h03:   value_out = 25'd50;
      5'h04:   value_out = 25'd100;
      5'h05:   value_out = 25'd250;
      5'h06:   value_out = 25'd500;
      5'h07:   value_out = 25'd1000;
      5'h08:   value_out = 25'd2500;
      5'h09:   value_out = 25'd5000;
      5'h0A:   value_out = 25'd7500;
      5'h0B:   value_out = 25'd10000;
      5'h0C:   value_out = 25'd12500;
      5'h0D:   value_out = 25'd15000;
      5'h0E:   value_out = 25'd20000;
      5'h0F:   value_out = 25'd30000;
      5'h10:   value_out = 25'd40000;
      5'h11:   value_out = 25'd50000;
      5'h12:   value_out = 25'd60000;
      5'h13:   value_out = 25'd75000;
      5'h14:   value_out = 25'd100000;
      5'h15:   value_out = 25'd125000;
      5'h16:   value_out = 25'd150000;
      5'h17:   value_out = 25'd175000;
      5'h18:   value_out = 25'd200000;
      5'h19:   value_out = 25'd250000;
      5'h1A:   value_out = 25'd300000;
      5'h1B:   value_out = 25'd400000;
      5'h1C:   value_out = 25'd500000;
      5'h1D:   value_out = 25'd750000;
      5'h1E:   value_out = 25'd1000000;
      default: value_out = SAT_VALUE;
    endcase
  end
endmodule

// >>> src/open_loop_startup_config.sv
// APB register and decoded settings for open-loop motor start-up
// Notes on behaviour
// RULE_01: 32-bit register at index 0x84, all defined fields read/write.
// RULE_02: Bit 30 picks open-loop limit: own field or general current limit.
// RULE_03: Bits 29:27 cap open-loop duty: 10,15,20,25,30,40,50,100 percent.
// RULE_04: Bits 26:23 threshold in 0.1 V steps, code 0 not applicable.
// RULE_05: Bits 22:18 first acceleration coefficient from 32-entry table.
// RULE_06: Code 0x1F means no acceleration limit, saturated value 32767.
// RULE_07: Bits 17:13 second coefficient, same numeric scale, per second squared.
// RULE_08: Bits 12:8 handoff frequency, 1 Hz at code 0 to 600 Hz.
// RULE_09: Bit 7 enables auto handoff; clear uses programmed threshold.
// RULE_10: Bit 6 set gives 0 Hz first cycle, else slow-first-cycle setting.
// RULE_11: Bits 5:2 minimum duty 1.5 to 25 percent; bits 1:0 read zero.
// RULE_12: Bit 31 stores software parity; all fields reset to zero.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module open_loop_startup_config #(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [ADDR_WIDTH-1:0] paddr_in,
  input  wire logic [31:0]           pwdata_in,
  input  wire logic [3:0]            pstrb_in,
  output logic                       pready_out,
  output logic                       pslverr_out,
  output logic      [31:0]           prdata_out,
  input  wire logic [3:0]            general_current_limit_in,
  input  wire logic [3:0]            slow_initial_cycle_freq_in,
  output logic                       parity_out,
  output logic                       limit_from_general_out,
  output logic      [3:0]            ol_limit_code_out,
  output logic      [10:0]           ol_current_threshold_mv_out,
  output logic      [9:0]            ceiling_a_out,
  output logic      [24:0]           accel_one_out,
  output logic                       accel_one_unlimited_out,
  output logic      [24:0]           accel_two_out,
  output logic                       accel_two_unlimited_out,
  output logic      [9:0]            handoff_freq_hz_out,
  output logic                       auto_handoff_out,
  output logic                       first_cycle_zero_out,
  output logic      [3:0]            first_cycle_code_out,
  output logic      [7:0]            min_duty_out
);
  generate
    if (ADDR_WIDTH < 12 || ADDR_WIDTH > 32) begin : g_bad_width
      $error("ADDR_WIDTH must be 12 to 32");
    end
  endgenerate

  logic [31:0] cfg;

  // Bus decode
  wire         addr_hit   = (paddr_in == ADDR_WIDTH'(startup_cfg_pkg::CFG_BYTE_ADDR));
  wire         setup      = psel_in && !penable_in;
  wire         access     = psel_in && penable_in;
  wire         write_hit  = access && pwrite_in && addr_hit;
  wire  [31:0] lane_mask  = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}},
                             {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
  wire  [31:0] wr_mask    = lane_mask & startup_cfg_pkg::CFG_WRITE_MASK;
  wire  [31:0] next_cfg   = (cfg & ~wr_mask) | (pwdata_in & wr_mask);

  assign pready_out  = access;
  assign pslverr_out = access && !addr_hit;

  // Field views
  wire       limit_sel   = cfg[startup_cfg_pkg::LIMIT_SEL_BIT];
  wire [2:0] ceiling_cd  = cfg[startup_cfg_pkg::CEILING_MSB:startup_cfg_pkg::CEILING_LSB];
  wire [3:0] thresh_cd   = cfg[startup_cfg_pkg::THRESH_MSB:startup_cfg_pkg::THRESH_LSB];
  wire [4:0] accel1_cd   = cfg[startup_cfg_pkg::ACCEL_ONE_MSB:startup_cfg_pkg::ACCEL_ONE_LSB];
  wire [4:0] accel2_cd   = cfg[startup_cfg_pkg::ACCEL_TWO_MSB:startup_cfg_pkg::ACCEL_TWO_LSB];
  wire [4:0] handoff_cd  = cfg[startup_cfg_pkg::HANDOFF_MSB:startup_cfg_pkg::HANDOFF_LSB];
  wire [3:0] min_duty_cd = cfg[startup_cfg_pkg::MIN_DUTY_MSB:startup_cfg_pkg::MIN_DUTY_LSB];
  wire       first_zero  = cfg[startup_cfg_pkg::FIRST_CYC_BIT];

  // Selected limit source
  wire [3:0]  limit_code = limit_sel ? general_current_limit_in : thresh_cd; // RULE_02
  wire [10:0] limit_mv   = 11'(limit_code * startup_cfg_pkg::THRESH_STEP_MV); // RULE_04

  logic [9:0]  ceiling_val;
  logic [9:0]  handoff_val;
  logic [7:0]  min_duty_val;
  logic [24:0] accel1_val;
  logic [24:0] accel2_val;
  logic        accel1_unl;
  logic        accel2_unl;

  // Duty ceiling in tenths of a percent
  always_comb begin
    case (ceiling_cd) // RULE_03
      3'h0:    ceiling_val = 10'd100;
      3'h1:    ceiling_val = 10'd150;
      3'h2:    ceiling_val = 10'd200;
      3'h3:    ceiling_val = 10'd250;
      3'h4:    ceiling_val = 10'd300;
      3'h5:    ceiling_val = 10'd400;
      3'h6:    ceiling_val = 10'd500;
      default: ceiling_val = 10'd1000;
    endcase
  end

  // Handoff frequency in hertz
  always_comb begin
    case (handoff_cd) // RULE_08
      5'h00:   handoff_val = 10'd1;
      5'h01:   handoff_val = 10'd4;
      5'h02:   handoff_val = 10'd8;
      5'h03:   handoff_val = 10'd12;
      5'h04:   handoff_val = 10'd16;
      5'h05:   handoff_val = 10'd20;
      5'h06:   handoff_val = 10'd24;
      5'h07:   handoff_val = 10'd28;
      5'h08:   handoff_val = 10'd32;
      5'h09:   handoff_val = 10'd36;
      5'h0A:   handoff_val = 10'd40;
      5'h0B:   handoff_val = 10'd45;
      5'h0C:   handoff_val = 10'd50;
      5'h0D:   handoff_val = 10'd55;
      5'h0E:   handoff_val = 10'd60;
      5'h0F:   handoff_val = 10'd65;
      5'h10:   handoff_val = 10'd70;
      5'h11:   handoff_val = 10'd75;
      5'h12:   handoff_val = 10'd80;
      5'h13:   handoff_val = 10'd85;
      5'h14:   handoff_val = 10'd90;
      5'h15:   handoff_val = 10'd100;
      5'h16:   handoff_val = 10'd150;
      5'h17:   handoff_val = 10'd200;
      5'h18:   handoff_val = 10'd250;
      5'h19:   handoff_val = 10'd300;
      5'h1A:   handoff_val = 10'd350;
      5'h1B:   handoff_val = 10'd400;
      5'h1C:   handoff_val = 10'd450;
      5'h1D:   handoff_val = 10'd500;
      5'h1E:   handoff_val = 10'd550;
      default: handoff_val = 10'd600;
    endcase
  end

  // Minimum duty in tenths of a percent; codes 0xE and 0xF both give 25 percent
  always_comb begin
    case (min_duty_cd) // RULE_11
      4'h0:    min_duty_val = 8'd15;
      4'h1:    min_duty_val = 8'd20;
      4'h2:    min_duty_val = 8'd30;
      4'h3:    min_duty_val = 8'd40;
      4'h4:    min_duty_val = 8'd50;
      4'h5:    min_duty_val = 8'd60;
      4'h6:    min_duty_val = 8'd70;
      4'h7:    min_duty_val = 8'd80;
      4'h8:    min_duty_val = 8'd90;
      4'h9:    min_duty_val = 8'd100;
      4'hA:    min_duty_val = 8'd120;
      4'hB:    min_duty_val = 8'd150;
      4'hC:    min_duty_val = 8'd175;
      4'hD:    min_duty_val = 8'd200;
      default: min_duty_val = 8'd250;
    endcase
  end

  // Same table serves both coefficients
  accel_coef_decoder accel_one_dec ( // RULE_05 RULE_06
    .code_in       (accel1_cd),
    .value_out     (accel1_val),
    .unlimited_out (accel1_unl)
  );

  accel_coef_decoder accel_two_dec ( // RULE_07 RULE_06
    .code_in       (accel2_cd),
    .value_out     (accel2_val),
    .unlimited_out (accel2_unl)
  );

  // Register store
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg <= startup_cfg_pkg::CFG_RESET; // RULE_12
    end else if (write_hit) begin
      cfg <= next_cfg; // RULE_01 RULE_11 RULE_12
    end
  end

  // Read data captured in setup phase
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup) begin
      prdata_out <= (addr_hit && !pwrite_in) ? cfg : 32'h0000_0000; // RULE_01
    end
  end

  // Decoded settings
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      parity_out                  <= 1'b0;
      limit_from_general_out      <= 1'b0;
      ol_limit_code_out           <= 4'h0;
      ol_current_threshold_mv_out <= 11'h000;
      ceiling_a_out               <= 10'h000;
      accel_one_out               <= 25'h000_0000;
      accel_one_unlimited_out     <= 1'b0;
      accel_two_out               <= 25'h000_0000;
      accel_two_unlimited_out     <= 1'b0;
      handoff_freq_hz_out         <= 10'h000;
      auto_handoff_out            <= 1'b0;
      first_cycle_zero_out        <= 1'b0;
      first_cycle_code_out        <= 4'h0;
      min_duty_out                <= 8'h00;
    end else begin
      parity_out                  <= cfg[startup_cfg_pkg::PARITY_BIT]; // RULE_12
      limit_from_general_out      <= limit_sel; // RULE_02
      ol_limit_code_out           <= limit_code; // RULE_02
      ol_current_threshold_mv_out <= limit_mv; // RULE_04
      ceiling_a_out               <= ceiling_val; // RULE_03
      accel_one_out               <= accel1_val; // RULE_05
      accel_one_unlimited_out     <= accel1_unl; // RULE_06
      accel_two_out               <= accel2_val; // RULE_07
      accel_two_unlimited_out     <= accel2_unl; // RULE_06
      handoff_freq_hz_out         <= handoff_val; // RULE_08
      auto_handoff_out            <= cfg[startup_cfg_pkg::AUTO_HANDOFF_BIT]; // RULE_09
      first_cycle_zero_out        <= first_zero; // RULE_10
      first_cycle_code_out        <= first_zero ? 4'h0 : slow_initial_cycle_freq_in; // RULE_10
      min_duty_out                <= min_duty_val; // RULE_11
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_write_lands: assert property ( // RULE_01
    write_hit && pstrb_in == 4'hF |=> cfg == ($past(pwdata_in) & 32'hFFFF_FFFC))
    else $error("full write not stored");
  a_read_back: assert property ( // RULE_01
    access && !pwrite_in && addr_hit |-> prdata_out == cfg && pready_out)
    else $error("read data differs from register");
  a_reserved_zero: assert property ( // RULE_11
    cfg[1:0] == 2'b00)
    else $error("reserved bits not zero");
  a_limit_source: assert property ( // RULE_02
    ##1 ol_limit_code_out ==
      ($past(cfg[30]) ? $past(general_current_limit_in) : $past(cfg[26:23])))
    else $error("wrong limit source");
  a_thresh_volts: assert property ( // RULE_04
    ##1 ol_current_threshold_mv_out == 11'(ol_limit_code_out * 11'd100))
    else $error("threshold scale wrong");
  a_ceiling_full: assert property ( // RULE_03
    cfg[29:27] == 3'h7 ##1 cfg[29:27] == 3'h7 |-> ceiling_a_out == 10'd1000)
    else $error("top duty ceiling not 100 percent");
  a_accel_saturate: assert property ( // RULE_06
    cfg[22:18] == 5'h1F |=> accel_one_out == 25'd32767000 && accel_one_unlimited_out)
    else $error("no-limit code not saturated");
  a_accel_two_base: assert property ( // RULE_07
    cfg[17:13] == 5'h00 |=> accel_two_out == 25'd5 && !accel_two_unlimited_out)
    else $error("second coefficient base wrong");
  a_handoff_top: assert property ( // RULE_08
    cfg[12:8] == 5'h1F |=> handoff_freq_hz_out == 10'd600)
    else $error("handoff top not 600 Hz");
  a_first_zero: assert property ( // RULE_10
    cfg[6] |=> first_cycle_zero_out && first_cycle_code_out == 4'h0)
    else $error("first cycle not forced to zero");
  a_reset_clear: assert property ( // RULE_12
    disable iff (1'b0) $past(reset_in) |-> cfg == 32'h0000_0000 && !parity_out)
    else $error("reset did not clear register");
endmodule

// >>> tb/tb_open_loop_startup_config.sv
// Self-checking bench for the open-loop start-up register block
`timescale 1ns/1ps
module tb_open_loop_startup_config;
  localparam logic [11:0] REG_ADDR = startup_cfg_pkg::CFG_BYTE_ADDR;
  logic        clk_in    = 1'b0;
  logic        reset_in  = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [3:0]  pstrb     = 4'h0;
  logic [3:0]  gen_limit = 4'h9;
  logic [3:0]  slow_freq = 4'h3;
  logic        pready, pslverr, parity, from_general, one_unl, two_unl, auto_ho, fzero;
  logic [31:0] prdata, rd_data;
  logic        rd_err;
  logic [3:0]  limit_code, fcode;
  logic [10:0] thresh_mv;
  logic [9:0]  ceiling, handoff;
  logic [24:0] accel_one, accel_two;
  logic [7:0]  min_duty;
  int          mismatches   = 0;
  int          total_checks = 0;

  always #12.5 clk_in = ~clk_in;

  open_loop_startup_config dut (
    .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .general_current_limit_in(gen_limit), .slow_initial_cycle_freq_in(slow_freq),
    .parity_out(parity), .limit_from_general_out(from_general),
    .ol_limit_code_out(limit_code), .ol_current_threshold_mv_out(thresh_mv),
    .ceiling_a_out(ceiling), .accel_one_out(accel_one), .accel_one_unlimited_out(one_unl),
    .accel_two_out(accel_two), .accel_two_unlimited_out(two_unl),
    .handoff_freq_hz_out(handoff), .auto_handoff_out(auto_ho),
    .first_cycle_zero_out(fzero), .first_cycle_code_out(fcode), .min_duty_out(min_duty)
  );

  task give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; response taken at the edge where pready is seen high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk_in);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      mismatches++;
      give_verdict();
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Full write, then wait until the decoded outputs carry the new value
  task wr(input logic [31:0] d, input logic [3:0] g, input logic [3:0] s);
    @(posedge clk_in);
    gen_limit <= g;
    slow_freq <= s;
    apb(1'b1, REG_ADDR, d, 4'hF);
    @(posedge clk_in);
    #1;
  endtask

  task t_reset;
    apb(1'b0, REG_ADDR, 32'h0000_0000, 4'h0);
    chk("reset reg", 32'h0000_0000, rd_data);
    chk("reset ceiling", 32'd100, ceiling);
    chk("reset accel one", 32'd5, accel_one);
    chk("reset accel two", 32'd5, accel_two);
    chk("reset mv", 32'd0, thresh_mv);
    chk("reset parity", 32'd0, parity);
    chk("reset handoff", 32'd1, handoff);
    chk("reset min duty", 32'd15, min_duty);
    chk("reset first code", 32'd3, fcode);
  endtask

  task t_duty;
    logic [9:0] tbl [8];
    tbl = '{10'd100, 10'd150, 10'd200, 10'd250, 10'd300, 10'd400, 10'd500, 10'd1000};
    for (int i = 0; i < 8; i++) begin
      wr({2'b00, i[2:0], 27'h0}, 4'h9, 4'h3);
      chk("ceiling", tbl[i], ceiling);
    end
  endtask

  task t_limit;
    wr(32'h0280_0000, 4'h9, 4'h3);
    chk("own code", 32'd5, limit_code);
    chk("own mv", 32'd500, thresh_mv);
    chk("source", 32'd0, from_general);
    wr(32'h4280_0000, 4'h9, 4'h3);
    chk("general code", 32'd9, limit_code);
    chk("general mv", 32'd900, thresh_mv);
    chk("source", 32'd1, from_general);
    wr(32'h0780_0000, 4'h9, 4'h3);
    chk("top mv", 32'd1500, thresh_mv);
  endtask

  task t_accel;
    logic [4:0]  code [4];
    logic [24:0] val [4];
    code = '{5'h00, 5'h07, 5'h1E, 5'h1F};
    val  = '{25'd5, 25'd1000, 25'd1000000, 25'd32767000};
    for (int i = 0; i < 4; i++) begin
      wr({9'h000, code[i], code[i], 13'h0000}, 4'h9, 4'h3);
      chk("accel one", val[i], accel_one);
      chk("accel two", val[i], accel_two);
      chk("unlimited one", {31'h0, code[i] == 5'h1F}, one_unl);
      chk("unlimited two", {31'h0, code[i] == 5'h1F}, two_unl);
    end
  endtask

  task t_handoff;
    logic [4:0] hc [3];
    logic [9:0] hz [3];
    logic [3:0] mc [3];
    logic [7:0] md [3];
    logic       b7, b6;
    hc = '{5'h00, 5'h15, 5'h1F};
    hz = '{10'd1, 10'd100, 10'd600};
    mc = '{4'h0, 4'hB, 4'hE};
    md = '{8'd15, 8'd150, 8'd250};
    for (int i = 0; i < 3; i++) begin
      b7 = (i != 1);
      b6 = (i != 0);
      wr({19'h0_0000, hc[i], b7, b6, mc[i], 2'b00}, 4'h9, 4'(i + 5));
      chk("handoff", hz[i], handoff);
      chk("min duty", md[i], min_duty);
      chk("auto handoff", {31'h0, b7}, auto_ho);
      chk("first zero", {31'h0, b6}, fzero);
      chk("first code", b6 ? 32'd0 : 32'(i + 5), fcode);
    end
  endtask

  task t_access;
    wr(32'hFFFF_FFFF, 4'h9, 4'h3);
    apb(1'b0, REG_ADDR, 32'h0000_0000, 4'h0);
    chk("all ones", 32'hFFFF_FFFC, rd_data);
    chk("parity", 32'd1, parity);
    apb(1'b1, REG_ADDR, 32'h0000_0000, 4'b0010);
    apb(1'b0, REG_ADDR, 32'h0000_0000, 4'h0);
    chk("lane write", 32'hFFFF_00FC, rd_data);
    apb(1'b1, REG_ADDR + 12'h004, 32'h0000_0000, 4'hF);
    chk("bad write err", 32'd1, rd_err);
    apb(1'b0, REG_ADDR + 12'h004, 32'h0000_0000, 4'h0);
    chk("bad read err", 32'd1, rd_err);
    chk("bad read data", 32'h0000_0000, rd_data);
    apb(1'b0, REG_ADDR, 32'h0000_0000, 4'h0);
    chk("kept", 32'hFFFF_00FC, rd_data);
    chk("good err", 32'd0, rd_err);
  endtask

  // Reset in mid-run must clear a register holding ones
  task t_midreset;
    @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    apb(1'b0, REG_ADDR, 32'h0000_0000, 4'h0);
    chk("midreset reg", 32'h0000_0000, rd_data);
    chk("midreset parity", 32'd0, parity);
    chk("midreset ceiling", 32'd100, ceiling);
    chk("midreset handoff", 32'd1, handoff);
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_duty();
    t_limit();
    t_accel();
    t_handoff();
    t_access();
    t_midreset();
    give_verdict();
  end
endmodule
